// ===== shared/mtl_consts.svh
// Constants of the multislot traffic loop controller: register offsets,
// command fields, opcodes, reset values and frame timing.
// Assumes inclusion by bare name from the shared folder.
`ifndef MTL_CONSTS_SVH
`define MTL_CONSTS_SVH

// Register byte offsets
`define MTL_REG_CMD        8'h00
`define MTL_REG_CFG        8'h04
`define MTL_REG_STAT       8'h08
`define MTL_REG_RTD        8'h0C

// Command register fields
`define MTL_CMD_OP         1:0
`define MTL_CMD_FRAME      2
`define MTL_CMD_MECH2      3
`define MTL_CMD_SLOT       6:4

// Command opcodes
`define MTL_OP_CLOSE_MS    2'h0
`define MTL_OP_OPEN_MS     2'h1
`define MTL_OP_CLOSE_SS    2'h2
`define MTL_OP_OPEN_SS     2'h3

// Configuration register fields and reset value
`define MTL_CFG_MAIN_UL    2:0
`define MTL_CFG_DL_MASK    15:8
`define MTL_CFG_UL_MASK    23:16
`define MTL_CFG_RESET      32'h0000_0000

// Status register fields
`define MTL_ST_CLOSED      0
`define MTL_ST_KIND        2:1
`define MTL_ST_MECH2       3
`define MTL_ST_SLOT        6:4
`define MTL_ST_TCH         8
`define MTL_ST_RSP         15:12

// Acknowledgement element bit set when a single-slot burst loop opens
`define MTL_ACK_ELEM_C     8'h01

// Datapath sizes and frame timing
`define MTL_SLOTS          8
`define MTL_SLOT_W         3
`define MTL_BURST_BITS     114
`define MTL_FRAME_BITS     260
`define MTL_RTD_FRAMES     5
`define MTL_RTD_LIMIT      26
`define MTL_REPORT_FRAMES  104

`endif

// ===== shared/mtl_pkg.sv
// Types of the multislot traffic loop controller.
// Assumes mtl_consts.svh is on the include path.
`include "mtl_consts.svh"

package mtl_pkg;

  // Kind of loop held in the record
  typedef enum logic [1:0] {
    MTL_LOOP_SS_BURST,
    MTL_LOOP_SS_OTHER,
    MTL_LOOP_MS_BURST,
    MTL_LOOP_MS_FRAME
  } mtl_kind_t;

  // Loop state record
  typedef struct packed {
    logic                   closed;
    mtl_kind_t              kind;
    logic                   mech2;
    logic [`MTL_SLOT_W-1:0] slot;
  } mtl_rec_t;

  // One burst of information bits, after decryption
  typedef struct packed {
    logic                       valid;
    logic                       traffic;
    logic                       normal_mid;
    logic [`MTL_SLOT_W-1:0]     slot;
    logic [`MTL_BURST_BITS-1:0] bits;
  } mtl_burst_t;

  // One decoded or to-be-encoded traffic frame
  typedef struct packed {
    logic                       valid;
    logic                       bad;
    logic                       facch;
    logic [`MTL_FRAME_BITS-1:0] bits;
  } mtl_frame_t;

  // Answers towards the simulator, one-cycle pulses
  typedef struct packed {
    logic       close_ack;
    logic       open_ack;
    logic       nack;
    logic       ss_open_ack;
    logic [7:0] ack_elem;
  } mtl_rsp_t;

endpackage

// ===== core/mtl_burst_delay.sv
// Burst ring buffer giving the fixed loop round trip delay in frames.
// Assumes a one-cycle frame_tick at every radio frame boundary.
`timescale 1ns/1ps
`include "mtl_consts.svh"

module mtl_burst_delay #(
  parameter int SLOTS = `MTL_SLOTS,
  parameter int DEPTH = `MTL_RTD_FRAMES,
  parameter int WIDTH = `MTL_BURST_BITS
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire logic                     frame_tick,
  input  wire logic                     flush,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(SLOTS)-1:0] wr_slot,
  input  wire logic [WIDTH-1:0]         wr_bits,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(SLOTS)-1:0] rd_slot,
  output logic                          rd_valid,
  output logic [WIDTH-1:0]              rd_bits
);
  localparam int RING = DEPTH + 1;
  localparam int SW   = $clog2(SLOTS);
  localparam int PW   = $clog2(RING);

  // Delay must stay under the round trip limit
  if (DEPTH < 1 || DEPTH >= `MTL_RTD_LIMIT || SLOTS != (1 << SW)) begin : g_bad
    $error("mtl_burst_delay: unsupported DEPTH or SLOTS");
  end

  logic [WIDTH-1:0]      mem [RING*SLOTS];
  logic [RING*SLOTS-1:0] vld_q;
  logic [PW-1:0]         wp_q;
  logic [PW-1:0]         rp;

  function automatic int idx(input logic [PW-1:0] p, input logic [SW-1:0] s);
    return int'(p) * SLOTS + int'(s);
  endfunction

  // Oldest frame sits one ahead of the write frame
  assign rp = (wp_q == PW'(RING - 1)) ? '0 : wp_q + 1'b1;

  // Frame pointer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_q <= '0;
    end else if (frame_tick) begin
      wp_q <= rp;
    end
  end

  // Occupancy flags; a write wins over a read of the same entry
  always_ff @(posedge sys_clk) begin
    if (reset || flush) begin
      vld_q <= '0;
    end else begin
      if (rd_en) begin
        vld_q[idx(rp, rd_slot)] <= 1'b0;
      end
      if (wr_en) begin
        vld_q[idx(wp_q, wr_slot)] <= 1'b1;
      end
    end
  end

  // Storage, order of arrival kept per slot
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[idx(wp_q, wr_slot)] <= wr_bits;
    end
  end

  // Read port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_bits  <= '0;
    end else begin
      rd_valid <= rd_en && vld_q[idx(rp, rd_slot)];
      rd_bits  <= mem[idx(rp, rd_slot)];
    end
  end
endmodule

// ===== core/mtl_frame_loop.sv
// Decoder-to-encoder frame loop with erased frame signalling.
// Assumes decoded frames arrive as one-cycle strobes with flags.
`timescale 1ns/1ps
`include "mtl_consts.svh"

module mtl_frame_loop (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               enable,
  input  wire mtl_pkg::mtl_frame_t dec_frame,
  output mtl_pkg::mtl_frame_t     enc_frame
);
  // Good frames pass, bad frames become zeros, FACCH left to its own path
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enc_frame <= '0;
    end else begin
      enc_frame <= '0;
      if (enable && dec_frame.valid && !dec_frame.facch) begin
        enc_frame.valid <= 1'b1;
        enc_frame.bits  <= dec_frame.bad ? '0 : dec_frame.bits;
      end
    end
  end

  chk_bad_zero: assert property (@(posedge sys_clk) disable iff (reset)
    enable && dec_frame.valid && dec_frame.bad && !dec_frame.facch
    |=> enc_frame.valid && enc_frame.bits == '0)
    else $error("bad frame not zeroed");

  chk_good_pass: assert property (@(posedge sys_clk) disable iff (reset)
    enable && dec_frame.valid && !dec_frame.bad && !dec_frame.facch
    |=> enc_frame.valid && enc_frame.bits == $past(dec_frame.bits))
    else $error("good frame not looped");

  chk_facch_free: assert property (@(posedge sys_clk) disable iff (reset)
    dec_frame.facch |=> !enc_frame.valid)
    else $error("FACCH frame fed to encoder");
endmodule

// ===== core/mtl_loop_ctrl.sv
// Multislot traffic loop controller: command interpreter, loop record,
// burst loop and erased-frame loop steering.
// Assumes commands arrive over the register port, bursts after decryption,
// and a one-cycle frame_tick at each radio frame.
`timescale 1ns/1ps
`include "mtl_consts.svh"

module mtl_loop_ctrl #(
  parameter int RTD_FRAMES = `MTL_RTD_FRAMES
) (
  input  wire logic                mtl_sys_clk_unused_guard,
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic                tch_active,
  input  wire logic                call_disconnect,
  input  wire logic                frame_tick,
  input  wire mtl_pkg::mtl_burst_t dl_burst,
  input  wire logic                ul_slot_req,
  input  wire logic [2:0]          ul_slot,
  output mtl_pkg::mtl_burst_t      ul_burst,
  input  wire mtl_pkg::mtl_frame_t dec_frame,
  output mtl_pkg::mtl_frame_t      enc_frame,
  output mtl_pkg::mtl_rsp_t        rsp,
  output logic                     loop_closed
);
  // Round trip delay must be fixed and short
  if (RTD_FRAMES < 1 || RTD_FRAMES >= `MTL_RTD_LIMIT) begin : g_bad_rtd
    $error("mtl_loop_ctrl: RTD_FRAMES out of range");
  end

  mtl_pkg::mtl_rec_t   rec_q;
  mtl_pkg::mtl_rec_t   rec_d;
  mtl_pkg::mtl_rsp_t   rsp_d;
  logic [31:0]         cfg_q;
  logic [3:0]          last_rsp_q;
  logic                cmd_v;
  logic [1:0]          cmd_op;
  logic                close_ok;
  logic                bad_slot;
  logic                open_ms_ok;
  logic                open_ss_ok;
  logic                loop_burst;
  logic                loop_frame;
  logic                take;
  logic [2:0]          target;
  logic                dly_valid;
  logic [`MTL_BURST_BITS-1:0] dly_bits;
  logic [2:0]          rd_slot_q;
  mtl_pkg::mtl_frame_t enc_w;
  logic [`MTL_SLOTS-1:0] dl_mask;
  logic [`MTL_SLOTS-1:0] ul_mask;

  // Command decode from the register port
  assign cmd_v  = reg_wr && reg_addr == `MTL_REG_CMD;
  assign cmd_op = reg_wdata[`MTL_CMD_OP];

  // Slot masks of the current configuration
  assign dl_mask = cfg_q[`MTL_CFG_DL_MASK];
  assign ul_mask = cfg_q[`MTL_CFG_UL_MASK];

  // Slot check applies to mechanism one only
  assign bad_slot = !reg_wdata[`MTL_CMD_MECH2]
                    && !dl_mask[reg_wdata[`MTL_CMD_SLOT]];

  // A close needs an active traffic channel and no loop closed
  assign close_ok   = cmd_v && !call_disconnect && tch_active && !rec_q.closed;
  assign open_ms_ok = cmd_v && !call_disconnect && cmd_op == `MTL_OP_OPEN_MS
                      && rec_q.closed && is_multi(rec_q.kind);
  assign open_ss_ok = cmd_v && !call_disconnect && cmd_op == `MTL_OP_OPEN_SS
                      && rec_q.closed && !is_multi(rec_q.kind);

  function automatic logic is_multi(input mtl_pkg::mtl_kind_t k);
    return k == mtl_pkg::MTL_LOOP_MS_BURST || k == mtl_pkg::MTL_LOOP_MS_FRAME;
  endfunction

  // Next record and answer; no other event touches the record
  always_comb begin
    rec_d = rec_q;
    rsp_d = '0;
    if (call_disconnect) begin
      rec_d = '0;
    end else if (close_ok && cmd_op == `MTL_OP_CLOSE_MS) begin
      if (bad_slot) begin
        rsp_d.nack = 1'b1;
      end else begin
        rec_d.closed = 1'b1;
        rec_d.kind   = reg_wdata[`MTL_CMD_FRAME] ? mtl_pkg::MTL_LOOP_MS_FRAME
                                                 : mtl_pkg::MTL_LOOP_MS_BURST;
        rec_d.mech2  = reg_wdata[`MTL_CMD_MECH2];
        rec_d.slot   = reg_wdata[`MTL_CMD_SLOT];
        rsp_d.close_ack = 1'b1;
      end
    end else if (close_ok && cmd_op == `MTL_OP_CLOSE_SS) begin
      rec_d.closed = 1'b1;
      rec_d.kind   = reg_wdata[`MTL_CMD_FRAME] ? mtl_pkg::MTL_LOOP_SS_OTHER
                                               : mtl_pkg::MTL_LOOP_SS_BURST;
      rec_d.mech2  = 1'b0;
      rec_d.slot   = reg_wdata[`MTL_CMD_SLOT];
      rsp_d.close_ack = 1'b1;
    end else if (open_ms_ok) begin
      rec_d = '0;
      rsp_d.open_ack = 1'b1;
    end else if (open_ss_ok) begin
      rec_d = '0;
      if (rec_q.kind == mtl_pkg::MTL_LOOP_SS_BURST) begin
        rsp_d.ss_open_ack = 1'b1;
        rsp_d.ack_elem    = `MTL_ACK_ELEM_C;
      end
    end
    // Opens with nothing closed fall through unanswered
  end

  // Loop record
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rec_q <= '0;
    end else begin
      rec_q <= rec_d;
    end
  end

  // Answer pulses and last answer code
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsp        <= '0;
      last_rsp_q <= '0;
    end else begin
      rsp <= rsp_d;
      if (|rsp_d[11:8]) begin
        last_rsp_q <= rsp_d[11:8];
      end
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_q <= `MTL_CFG_RESET;
    end else if (reg_wr && reg_addr == `MTL_REG_CFG) begin
      cfg_q <= reg_wdata;
    end
  end

  // Read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `MTL_REG_CFG: begin
            reg_rdata <= cfg_q;
          end
          `MTL_REG_STAT: begin
            reg_rdata[`MTL_ST_CLOSED] <= rec_q.closed;
            reg_rdata[`MTL_ST_KIND]   <= rec_q.kind;
            reg_rdata[`MTL_ST_MECH2]  <= rec_q.mech2;
            reg_rdata[`MTL_ST_SLOT]   <= rec_q.slot;
            reg_rdata[`MTL_ST_TCH]    <= tch_active;
            reg_rdata[`MTL_ST_RSP]    <= last_rsp_q;
          end
          `MTL_REG_RTD: begin
            reg_rdata <= 32'(RTD_FRAMES);
          end
          default: begin
            reg_rdata <= '0;
          end
        endcase
      end
    end
  end

  // Loop enables; no SIM condition gates them
  assign loop_burst = rec_q.closed && (rec_q.kind == mtl_pkg::MTL_LOOP_MS_BURST
                      || rec_q.kind == mtl_pkg::MTL_LOOP_SS_BURST);
  assign loop_frame = rec_q.closed && (rec_q.kind == mtl_pkg::MTL_LOOP_MS_FRAME
                      || rec_q.kind == mtl_pkg::MTL_LOOP_SS_OTHER);

  // Slot selection; only traffic bursts, any midamble state
  always_comb begin
    take   = 1'b0;
    target = dl_burst.slot;
    if (loop_burst && dl_burst.valid && dl_burst.traffic) begin
      if (rec_q.mech2) begin
        take = dl_mask[dl_burst.slot]
               && ul_mask[dl_burst.slot];
      end else begin
        take = dl_burst.slot == rec_q.slot;
        if (rec_q.kind == mtl_pkg::MTL_LOOP_MS_BURST) begin
          target = cfg_q[`MTL_CFG_MAIN_UL];
        end
      end
    end
  end

  // Fixed delay line of raw burst bits, in arrival order
  mtl_burst_delay #(
    .SLOTS (`MTL_SLOTS),
    .DEPTH (RTD_FRAMES),
    .WIDTH (`MTL_BURST_BITS)
  ) u_delay (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .frame_tick (frame_tick),
    .flush      (!loop_burst),
    .wr_en      (take),
    .wr_slot    (target),
    .wr_bits    (dl_burst.bits),
    .rd_en      (ul_slot_req && loop_burst),
    .rd_slot    (ul_slot),
    .rd_valid   (dly_valid),
    .rd_bits    (dly_bits)
  );

  // Slot of the pending uplink read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_slot_q <= '0;
    end else begin
      rd_slot_q <= ul_slot;
    end
  end

  // Uplink burst with the station's own midamble
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ul_burst <= '0;
    end else begin
      ul_burst            <= '0;
      ul_burst.valid      <= dly_valid;
      ul_burst.traffic    <= dly_valid;
      ul_burst.normal_mid <= dly_valid;
      ul_burst.slot       <= rd_slot_q;
      ul_burst.bits       <= dly_bits;
    end
  end

  // Erased-frame loop between decoder and encoder
  mtl_frame_loop u_frame (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .enable    (loop_frame),
    .dec_frame (dec_frame),
    .enc_frame (enc_w)
  );

  // Registered frame and loop status outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enc_frame   <= '0;
      loop_closed <= 1'b0;
    end else begin
      enc_frame   <= enc_w;
      loop_closed <= rec_q.closed;
    end
  end

  // Frames since the last close acknowledgement of any loop kind
  logic [6:0] ack_frames_q;
  always_ff @(posedge sys_clk) begin
    if (reset || rsp.close_ack) begin
      ack_frames_q <= '0;
    end else if (frame_tick && ack_frames_q != 7'(`MTL_REPORT_FRAMES)) begin
      ack_frames_q <= ack_frames_q + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_open_ms_ack: assert property (open_ms_ok |=> rsp.open_ack && !rec_q.closed)
    else $error("multislot open not acknowledged");

  chk_open_ignored: assert property (
    cmd_v && !call_disconnect && !rec_q.closed && cmd_op[0]
    |=> rsp == '0 && !rec_q.closed)
    else $error("open without closed loop answered");

  chk_nack_keeps: assert property (
    close_ok && cmd_op == `MTL_OP_CLOSE_MS && bad_slot
    |=> rsp.nack && !rsp.close_ack && rec_q == $past(rec_q))
    else $error("bad slot changed loop state");

  chk_close_replace: assert property (
    close_ok && cmd_op == `MTL_OP_CLOSE_MS && !bad_slot
    |=> rec_q.closed && rec_q.slot == $past(reg_wdata[`MTL_CMD_SLOT])
        && rec_q.mech2 == $past(reg_wdata[`MTL_CMD_MECH2]) && rsp.close_ack)
    else $error("close did not replace record");

  chk_disc_silent: assert property (
    call_disconnect |=> !rec_q.closed && !rsp.open_ack && !rsp.ss_open_ack)
    else $error("disconnect left loop or acknowledged");

  chk_close_drop: assert property (
    cmd_v && !cmd_op[0] && !call_disconnect && (!tch_active || rec_q.closed)
    |=> $stable(rec_q) && rsp == '0)
    else $error("close accepted when not allowed");

  chk_ss_open_elem: assert property (
    open_ss_ok && rec_q.kind == mtl_pkg::MTL_LOOP_SS_BURST
    |=> rsp.ss_open_ack && rsp.ack_elem[0] && !rec_q.closed)
    else $error("single-slot open element bit missing");

  chk_loop_running: assert property (
    rsp.close_ack && rec_q.kind == mtl_pkg::MTL_LOOP_MS_BURST
    |-> loop_burst ##1 (loop_burst || !rec_q.closed))
    else $error("burst loop not running after ack");

  chk_ack_window: assert property (
    rec_q.closed && rec_q.kind == mtl_pkg::MTL_LOOP_MS_BURST
    |-> loop_burst || ack_frames_q < 7'(`MTL_REPORT_FRAMES))
    else $error("burst loop late beyond reporting period");

  chk_no_control: assert property (
    dl_burst.valid && !dl_burst.traffic |-> !take)
    else $error("control burst looped");

  chk_midamble: assert property (ul_burst.valid |-> ul_burst.normal_mid)
    else $error("uplink burst without normal midamble");

  chk_mech2_map: assert property (
    take && rec_q.mech2 |-> target == dl_burst.slot
    && ul_mask[dl_burst.slot])
    else $error("unidirectional slot looped");

  cov_close_ms: cover property (rsp.close_ack ##[1:50] rsp.open_ack);
  cov_nack: cover property (rsp.nack);
  cov_loop_burst: cover property (take ##[1:300] ul_burst.valid);
  cov_disc: cover property (loop_closed ##1 call_disconnect);
endmodule

// ===== test/mtl_sim_model.sv
// Simulator-side model: radio frame pulse and close acknowledgement timer.
// Assumes command writes and answers of the loop controller are visible.
`timescale 1ns/1ps

module mtl_sim_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       cmd_sent,
  input  wire logic       ack_seen,
  output logic            frame_tick,
  output logic [7:0]      close_ack_timer_q
);
  logic [3:0] frame_cnt_q;
  logic       timing_q;

  // Radio frame pulse every 16 cycles
  always_ff @(posedge sys_clk) begin
    frame_cnt_q <= reset ? 4'h0 : frame_cnt_q + 4'h1;
  end
  assign frame_tick = (frame_cnt_q == 4'hf);

  // Timer runs from any command write to the next close acknowledgement
  always_ff @(posedge sys_clk) begin
    if (reset || ack_seen) begin
      timing_q <= 1'b0;
    end else if (cmd_sent) begin
      timing_q <= 1'b1;
    end
    if (reset || cmd_sent) begin
      close_ack_timer_q <= 8'h00;
    end else if (timing_q) begin
      close_ack_timer_q <= close_ack_timer_q + 8'h01;
    end
  end
endmodule

// ===== test/test_multislot_traffic_loop_control.sv
// Testbench of the loop controller: register commands, burst and frame loops.
// Assumes the simulator model supplies frame pulses.
`timescale 1ns/1ps
`include "mtl_consts.svh"

module test_multislot_traffic_loop_control;
  localparam int LOOP_ROUND_TRIP_DELAY = 5;
  localparam logic [259:0] PAT = {4'b1010, {16{16'ha5c3}}};
  logic                sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic                tch_active = 1'b0, call_disconnect = 1'b0, ul_slot_req = 1'b0;
  logic                frame_tick, loop_closed;
  logic [7:0]          reg_addr = 8'h00, timer_q;
  logic [31:0]         reg_wdata = 32'h0000_0000, reg_rdata;
  logic [2:0]          ul_slot = 3'h0;
  mtl_pkg::mtl_burst_t dl_burst = '0, ul_burst;
  mtl_pkg::mtl_frame_t dec_frame = '0, enc_frame;
  mtl_pkg::mtl_rsp_t   rsp;
  int                  failures = 0, total_checks = 0;

  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  mtl_loop_ctrl #(.RTD_FRAMES(LOOP_ROUND_TRIP_DELAY)) dut (.mtl_sys_clk_unused_guard(1'b0), .sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tch_active(tch_active), .call_disconnect(call_disconnect), .frame_tick(frame_tick), .dl_burst(dl_burst),
    .ul_slot_req(ul_slot_req), .ul_slot(ul_slot), .ul_burst(ul_burst), .dec_frame(dec_frame),
    .enc_frame(enc_frame), .rsp(rsp), .loop_closed(loop_closed));
  mtl_sim_model sim (.sys_clk(sys_clk), .reset(reset), .cmd_sent(reg_wr && reg_addr == `MTL_REG_CMD),
    .ack_seen(rsp.close_ack), .frame_tick(frame_tick), .close_ack_timer_q(timer_q));

  task automatic check(input logic [259:0] got, input logic [259:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // Command write, answer compared in the following cycle
  task automatic cmd(input logic [31:0] d, input logic [11:0] exp);
    wr(`MTL_REG_CMD, d);
    #1 check(rsp, exp);
  endtask
  // Burst on a downlink slot, read back LOOP_ROUND_TRIP_DELAY frames later on an uplink slot
  task automatic loop_burst(input logic [2:0] dls, input logic [2:0] uls, input logic hit, input logic tr);
    @(posedge sys_clk);
    dl_burst <= '{1'b1, tr, 1'b0, dls, PAT[113:0]};
    @(posedge sys_clk);
    dl_burst <= '0;
    repeat (LOOP_ROUND_TRIP_DELAY) @(posedge frame_tick);
    @(posedge sys_clk);
    ul_slot_req <= 1'b1;
    ul_slot <= uls;
    @(posedge sys_clk);
    ul_slot_req <= 1'b0;
    @(posedge sys_clk);
    #1 check({ul_burst.valid, ul_burst.normal_mid}, {hit, hit});
    if (hit) check(ul_burst.bits, PAT[113:0]);
  endtask
  task automatic frame(input logic bad, input logic fa, input logic [259:0] exp);
    @(posedge sys_clk);
    dec_frame <= '{1'b1, bad, fa, PAT};
    @(posedge sys_clk);
    dec_frame <= '0;
    @(posedge sys_clk);
    #1 check({enc_frame.valid, enc_frame.bits}, {!fa, exp});
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #300000;
    failures++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd(`MTL_REG_CFG, `MTL_CFG_RESET);
    rd(`MTL_REG_RTD, LOOP_ROUND_TRIP_DELAY);
    rd(8'h10, 32'h0000_0000);
    wr(`MTL_REG_CFG, 32'h0008_0C01);
    cmd(32'h0000_0020, 12'h000);
    @(posedge sys_clk);
    tch_active <= 1'b1;
    cmd(32'h0000_0020, 12'h800);
    rd(`MTL_REG_STAT, 32'h0000_8125);
    check(timer_q, 8'h01);
    cmd(32'h0000_0030, 12'h000);
    $display("test close done");
    loop_burst(3'h2, 3'h1, 1'b1, 1'b1);
    cmd(32'h0000_0001, 12'h400);
    cmd(32'h0000_0001, 12'h000);
    cmd(32'h0000_0050, 12'h200);
    rd(`MTL_REG_STAT, 32'h0000_2100);
    cmd(32'h0000_0008, 12'h800);
    loop_burst(3'h3, 3'h3, 1'b1, 1'b1);
    loop_burst(3'h3, 3'h3, 1'b0, 1'b0);
    loop_burst(3'h2, 3'h2, 1'b0, 1'b1);
    cmd(32'h0000_0001, 12'h400);
    $display("test burst loop done");
    cmd(32'h0000_0024, 12'h800);
    frame(1'b1, 1'b0, 260'h0);
    frame(1'b0, 1'b0, PAT);
    frame(1'b0, 1'b1, 260'h0);
    @(posedge sys_clk);
    call_disconnect <= 1'b1;
    @(posedge sys_clk);
    call_disconnect <= 1'b0;
    @(posedge sys_clk);
    #1 check({rsp, loop_closed}, 13'h0000);
    $display("test frame loop done");
    cmd(32'h0000_0002, 12'h800);
    cmd(32'h0000_0003, 12'h101);
    cmd(32'h0000_0003, 12'h000);
    $display("test single slot done");
    summarize();
  end
endmodule
